// File: rfm_map.sv
// Functional notes
// - 16-bit program path, separate 8-bit register path
// - Low 256 program bytes hold vectors
// - Fetch starts at 0100H by default
// - Option area 003CH-003FH, only 3EH/3FH used
// - Stores to option area leave options unchanged
// - Bit 3EH.7 low relocates vector via 3EH.6:5
// - Programming area 0100H to below vector
// - Protection bit low refuses area erase/program
// - Protection bit high ignores size bits
// - 256 physical bytes appear as 320
// - Set 1 is C0H-FFH
// - E0H-FFH has two banks, reset bank 0
// - D0H-DFH system, C0H-CFH common area
// - Set 1 reached only by direct or working addressing
// - Indirect/indexed C0H-FFH goes to set 2
// - Page select DFH, low source, high destination
// - Reset clears both page nibbles
// - 00H-BFH prime area on selected page
// - Page 15 holds display data and peripheral control
// - Common area only by working addressing
// - Working address uses slice pointer and low bits
// - Slice pointers D6H/D7H reset C0H/C8H
`timescale 1ns/1ns
module rfm_map
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire rfm_pkg::rfm_reg_req_t reg_req,
    input  wire logic                  select_lower_bank_instr,
    input  wire logic                  select_upper_bank_instr,
    input  wire rfm_pkg::rfm_prog_req_t prog_req,
    input  wire logic [7:0]            option_isp_byte,
    output logic [7:0]                 reg_rdata,
    output logic                       reg_rvalid,
    output logic                       reg_refused,
    output logic                       display_page_hit,
    output logic                       periph_ctrl_hit,
    output logic [7:0]                 register_page_select,
    output logic [7:0]                 working_slice_pointer_a,
    output logic [7:0]                 working_slice_pointer_b,
    output logic                       bank_select,
    output logic [15:0]                fetch_start,
    output logic                       prog_vector_hit,
    output logic                       prog_option_hit,
    output logic                       prog_refused,
    output logic                       prog_accept,
    output logic [15:0]                prog_addr
);
    import rfm_pkg::*;

    logic [15:0] reset_vector;
    logic [15:0] isp_end;
    logic        isp_protect;
    logic [1:0]  isp_prot_size;

    // Options latched in the sub-block; stores never reach it
    rfm_boot_opt u_opt (
        .clk             (clk),
        .rstn            (rstn),
        .option_isp_byte (option_isp_byte),
        .reset_vector    (reset_vector),
        .isp_end         (isp_end),
        .isp_protect     (isp_protect),
        .isp_prot_size   (isp_prot_size)
    );

    // Protected span end: last of 256 << size bytes from 0100H
    function automatic logic [15:0] prot_end(input logic [1:0] sz);
        logic [15:0] span;
        span = 16'h0100 << sz;
        return RFM_RESET_VECTOR + span - 16'h0001;
    endfunction

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // Program memory side
    logic        next_prog_vector_hit;
    logic        next_prog_option_hit;
    logic        next_prog_refused;
    logic        next_prog_accept;
    logic [15:0] next_prog_addr;
    logic [15:0] next_fetch_start;

    always_comb begin
        next_prog_addr       = prog_addr;
        next_prog_vector_hit = 1'b0;
        next_prog_option_hit = 1'b0;
        next_prog_refused    = 1'b0;
        next_prog_accept     = 1'b0;
        next_fetch_start     = reset_vector;
        if (prog_req.valid) begin
            next_prog_addr       = prog_req.addr;
            next_prog_vector_hit = prog_req.addr <= RFM_VECTOR_END;
            next_prog_option_hit = in_range(prog_req.addr, RFM_OPTION_LO, RFM_OPTION_HI);
            if (prog_req.program_op && isp_protect
                && in_range(prog_req.addr, RFM_RESET_VECTOR, prot_end(isp_prot_size))) begin
                next_prog_refused = 1'b1;
            end else begin
                // Vector area still ordinary memory; option stores change only stored bytes
                next_prog_accept = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prog_addr       <= 16'h0000;
            prog_vector_hit <= 1'b0;
            prog_option_hit <= 1'b0;
            prog_refused    <= 1'b0;
            prog_accept     <= 1'b0;
            fetch_start     <= RFM_RESET_VECTOR;
        end else begin
            prog_addr       <= next_prog_addr;
            prog_vector_hit <= next_prog_vector_hit;
            prog_option_hit <= next_prog_option_hit;
            prog_refused    <= next_prog_refused;
            prog_accept     <= next_prog_accept;
            fetch_start     <= next_fetch_start;
        end
    end

    // Register file side
    logic [7:0]  next_page;
    logic [7:0]  next_slice_a;
    logic [7:0]  next_slice_b;
    logic        next_bank;
    logic [11:0] prime_addr;
    logic [10:0] upper_addr;
    logic        prime_we;
    logic        upper_we;
    logic [7:0]  prime_rdata;
    logic [7:0]  upper_rdata;
    logic [7:0]  eff_addr;
    rfm_area_t   area;
    logic [3:0]  page;
    logic        hit;
    logic        next_rvalid;
    logic        next_refused;
    logic        next_disp;
    logic        next_periph;
    logic        sel_sys;
    logic        next_sel_sys;
    logic [7:0]  sys_rdata;
    logic [7:0]  next_sys_rdata;

    // Working form: pointer top five bits plus low three bits
    function automatic logic [7:0] working_addr(input logic [3:0] r, input logic [7:0] pa, input logic [7:0] pb);
        return {(r[3] ? pb[7:3] : pa[7:3]), r[2:0]};
    endfunction

    always_comb begin
        page     = reg_req.dest ? register_page_select[7:4] : register_page_select[3:0];
        eff_addr = reg_req.addr;
        area     = RFM_AREA_NONE;
        if (reg_req.mode == RFM_MODE_WORKING) begin
            eff_addr = working_addr(reg_req.addr[3:0], working_slice_pointer_a, working_slice_pointer_b);
        end
        if (eff_addr < RFM_SET1_BASE) begin
            area = RFM_AREA_PRIME;
        end else if (reg_req.mode == RFM_MODE_INDIRECT || reg_req.mode == RFM_MODE_INDEXED) begin
            area = RFM_AREA_SET2;
        end else if (eff_addr >= RFM_BANKED_BASE) begin
            area = RFM_AREA_SET1_BANK;
        end else if (eff_addr >= RFM_SYSREG_BASE) begin
            area = RFM_AREA_SET1_SYS;
        end else if (reg_req.mode == RFM_MODE_WORKING) begin
            area = RFM_AREA_SET1_COMMON;
        end
        hit = reg_req.valid && (area != RFM_AREA_NONE);
    end

    // One 4K prime store; set 2 pages and set 1 banked/common registers share a second store
    always_comb begin
        prime_addr = {page, eff_addr};
        prime_we   = hit && reg_req.write && (area == RFM_AREA_PRIME);
        upper_we   = hit && reg_req.write && (area != RFM_AREA_PRIME) && (area != RFM_AREA_SET1_SYS);
        case (area)
            RFM_AREA_SET2:        upper_addr = {1'b1, page, eff_addr[5:0]};
            RFM_AREA_SET1_BANK:   upper_addr = {5'h01, bank_select, eff_addr[4:0]};
            default:              upper_addr = {7'h00, eff_addr[3:0]};
        endcase
    end

    rfm_store #(.DEPTH(4096), .AW(12)) u_prime (
        .clk   (clk),
        .we    (prime_we),
        .waddr (prime_addr),
        .wdata (reg_req.wdata),
        .raddr (prime_addr),
        .rdata (prime_rdata)
    );

    rfm_store #(.DEPTH(2048), .AW(11)) u_upper (
        .clk   (clk),
        .we    (upper_we),
        .waddr (upper_addr),
        .wdata (reg_req.wdata),
        .raddr (upper_addr),
        .rdata (upper_rdata)
    );

    always_comb begin
        next_page      = register_page_select;
        next_slice_a   = working_slice_pointer_a;
        next_slice_b   = working_slice_pointer_b;
        next_bank      = bank_select;
        next_rvalid    = hit && !reg_req.write;
        next_refused   = reg_req.valid && !hit;
        next_disp      = hit && area == RFM_AREA_PRIME && page == RFM_DISPLAY_PAGE
                         && eff_addr <= RFM_DISPLAY_END;
        next_periph    = hit && area == RFM_AREA_PRIME && page == RFM_DISPLAY_PAGE
                         && eff_addr == RFM_PERIPH_CTRL_ADDR;
        next_sel_sys   = hit && area == RFM_AREA_SET1_SYS;
        next_sys_rdata = 8'h00;
        if (hit && area == RFM_AREA_SET1_SYS) begin
            if (eff_addr == RFM_PAGE_SELECT_ADDR) begin
                next_sys_rdata = register_page_select;
                if (reg_req.write) next_page = reg_req.wdata;
            end else if (eff_addr == RFM_SLICE_A_ADDR) begin
                next_sys_rdata = working_slice_pointer_a;
                if (reg_req.write) next_slice_a = reg_req.wdata;
            end else if (eff_addr == RFM_SLICE_B_ADDR) begin
                next_sys_rdata = working_slice_pointer_b;
                if (reg_req.write) next_slice_b = reg_req.wdata;
            end
        end
        // Upper select wins if both arrive together
        if (select_upper_bank_instr) begin
            next_bank = 1'b1;
        end else if (select_lower_bank_instr) begin
            next_bank = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            register_page_select    <= RFM_PAGE_SELECT_RESET;
            working_slice_pointer_a <= RFM_SLICE_A_RESET;
            working_slice_pointer_b <= RFM_SLICE_B_RESET;
            bank_select             <= 1'b0;
            reg_rvalid              <= 1'b0;
            reg_refused             <= 1'b0;
            display_page_hit        <= 1'b0;
            periph_ctrl_hit         <= 1'b0;
            sel_sys                 <= 1'b0;
            sys_rdata               <= 8'h00;
        end else begin
            register_page_select    <= next_page;
            working_slice_pointer_a <= next_slice_a;
            working_slice_pointer_b <= next_slice_b;
            bank_select             <= next_bank;
            reg_rvalid              <= next_rvalid;
            reg_refused             <= next_refused;
            display_page_hit        <= next_disp;
            periph_ctrl_hit         <= next_periph;
            sel_sys                 <= next_sel_sys;
            sys_rdata               <= next_sys_rdata;
        end
    end

    // Store data arrives one cycle after the request, aligned with reg_rvalid
    logic       prime_sel;
    logic       next_prime_sel;

    always_comb begin
        next_prime_sel = area == RFM_AREA_PRIME;
        reg_rdata      = sel_sys ? sys_rdata : (prime_sel ? prime_rdata : upper_rdata);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prime_sel <= 1'b0;
        end else begin
            prime_sel <= next_prime_sel;
        end
    end
endmodule // rfm_map

// File: rfm_pkg.sv
package rfm_pkg;

    localparam logic [7:0]  RFM_PAGE_SELECT_ADDR  = 8'hDF;
    localparam logic [7:0]  RFM_PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0]  RFM_SLICE_A_ADDR      = 8'hD6;
    localparam logic [7:0]  RFM_SLICE_B_ADDR      = 8'hD7;
    localparam logic [7:0]  RFM_SLICE_A_RESET     = 8'hC0;
    localparam logic [7:0]  RFM_SLICE_B_RESET     = 8'hC8;
    localparam logic [7:0]  RFM_SET1_BASE         = 8'hC0;
    localparam logic [7:0]  RFM_BANKED_BASE       = 8'hE0;
    localparam logic [7:0]  RFM_SYSREG_BASE       = 8'hD0;
    localparam logic [7:0]  RFM_DISPLAY_END       = 8'hAF;
    localparam logic [7:0]  RFM_PERIPH_CTRL_ADDR  = 8'hB0;
    localparam logic [3:0]  RFM_DISPLAY_PAGE      = 4'hF;

    localparam logic [15:0] RFM_VECTOR_END        = 16'h00FF;
    localparam logic [15:0] RFM_RESET_VECTOR      = 16'h0100;
    localparam logic [15:0] RFM_OPTION_LO         = 16'h003C;
    localparam logic [15:0] RFM_OPTION_HI         = 16'h003F;
    localparam logic [15:0] RFM_OPTION_ISP        = 16'h003E;
    localparam logic [15:0] RFM_OPTION_SYS        = 16'h003F;
    localparam logic [7:0]  RFM_OPTION_ERASED     = 8'hFF;
    localparam int          RFM_VEC_EN_BIT        = 7;
    localparam int          RFM_VEC_SEL_HI        = 6;
    localparam int          RFM_VEC_SEL_LO        = 5;
    localparam int          RFM_PROT_EN_BIT       = 2;
    localparam int          RFM_PROT_SEL_HI       = 1;
    localparam int          RFM_PROT_SEL_LO       = 0;
    localparam logic [15:0] RFM_VEC_0200          = 16'h0200;
    localparam logic [15:0] RFM_VEC_0300          = 16'h0300;
    localparam logic [15:0] RFM_VEC_0500          = 16'h0500;
    localparam logic [15:0] RFM_VEC_0900          = 16'h0900;

    typedef enum logic [1:0] {
        RFM_MODE_DIRECT,
        RFM_MODE_INDIRECT,
        RFM_MODE_INDEXED,
        RFM_MODE_WORKING
    } rfm_mode_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       dest;
        rfm_mode_t  mode;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rfm_reg_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        program_op;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } rfm_prog_req_t;

    typedef enum logic [2:0] {
        RFM_AREA_PRIME,
        RFM_AREA_SET1_COMMON,
        RFM_AREA_SET1_SYS,
        RFM_AREA_SET1_BANK,
        RFM_AREA_SET2,
        RFM_AREA_NONE
    } rfm_area_t;

endpackage

// File: rfm_store.sv
`timescale 1ns/1ns
module rfm_store #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic [7:0]         rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // rfm_store

// File: rfm_boot_opt.sv
`timescale 1ns/1ns
module rfm_boot_opt
    import rfm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  option_isp_byte,
    output logic [15:0]      reset_vector,
    output logic [15:0]      isp_end,
    output logic             isp_protect,
    output logic [1:0]       isp_prot_size
);
    logic [7:0] opt;
    logic [7:0] next_opt;

    // Programmer-written option pins are captured only while reset is held
    always_comb begin
        next_opt = rstn ? opt : option_isp_byte;
    end

    always_ff @(posedge clk) begin
        opt <= next_opt;
    end

    always_comb begin
        reset_vector = RFM_RESET_VECTOR;
        isp_end      = RFM_RESET_VECTOR;
        if (!opt[RFM_VEC_EN_BIT]) begin
            case ({opt[RFM_VEC_SEL_HI], opt[RFM_VEC_SEL_LO]})
                2'h0: reset_vector = RFM_VEC_0200;
                2'h1: reset_vector = RFM_VEC_0300;
                2'h2: reset_vector = RFM_VEC_0500;
                default: reset_vector = RFM_VEC_0900;
            endcase
            isp_end = reset_vector - 16'h0001;
        end
        isp_protect   = !opt[RFM_PROT_EN_BIT];
        isp_prot_size = isp_protect ? {opt[RFM_PROT_SEL_HI], opt[RFM_PROT_SEL_LO]} : 2'h0;
    end
endmodule // rfm_boot_opt

// File: rfm_map_asserts.sv
`timescale 1ns/1ns
module rfm_map_asserts
    import rfm_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire rfm_pkg::rfm_reg_req_t  reg_req,
    input  wire logic                   select_lower_bank_instr,
    input  wire logic                   select_upper_bank_instr,
    input  wire rfm_pkg::rfm_prog_req_t prog_req,
    input  wire logic [7:0]             option_isp_byte,
    input  wire logic [7:0]             reg_rdata,
    input  wire logic                   reg_rvalid,
    input  wire logic                   reg_refused,
    input  wire logic [7:0]             register_page_select,
    input  wire logic [7:0]             working_slice_pointer_a,
    input  wire logic [7:0]             working_slice_pointer_b,
    input  wire logic                   bank_select,
    input  wire logic [15:0]            fetch_start,
    input  wire logic                   prog_vector_hit,
    input  wire logic                   prog_refused,
    input  wire logic                   prog_accept,
    input  wire logic [15:0]            prog_addr
);
    logic [7:0]  opt_q;
    logic [7:0]  next_opt;
    logic [15:0] exp_vec;
    logic        in_prot;

    // Options only move while reset is low
    always_comb begin
        next_opt = rstn ? opt_q : option_isp_byte;
        case (opt_q[6:5])
            2'h0: exp_vec = 16'h0200;
            2'h1: exp_vec = 16'h0300;
            2'h2: exp_vec = 16'h0500;
            default: exp_vec = 16'h0900;
        endcase
        if (opt_q[7]) begin
            exp_vec = 16'h0100;
        end
        in_prot = !opt_q[2] && prog_req.addr >= 16'h0100 && prog_req.addr < 16'h0100 + (16'h0100 << opt_q[1:0]);
    end

    always_ff @(posedge clk) begin
        opt_q <= next_opt;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_settled;
        rstn [*4];
    endsequence
    sequence s_read_pp;
        reg_req.valid && !reg_req.write && reg_req.mode == RFM_MODE_DIRECT && reg_req.addr == 8'hDF;
    endsequence
    sequence s_write_pp;
        reg_req.valid && reg_req.write && reg_req.mode == RFM_MODE_DIRECT && reg_req.addr == 8'hDF;
    endsequence

    a_reset_values: assert property (disable iff (1'b0) !rstn |=> register_page_select == 8'h00
        && working_slice_pointer_a == 8'hC0 && working_slice_pointer_b == 8'hC8 && !bank_select && fetch_start == 16'h0100)
        else $error("reset values wrong");
    a_page_read: assert property (s_read_pp |=> reg_rvalid && reg_rdata == register_page_select)
        else $error("page select read wrong");
    a_page_write: assert property (s_write_pp |=> register_page_select == $past(reg_req.wdata))
        else $error("page select write lost");
    a_common_refused: assert property (reg_req.valid && reg_req.mode == RFM_MODE_DIRECT
        && reg_req.addr[7:4] == 4'hC |=> reg_refused && !reg_rvalid) else $error("common area not refused");
    a_bank_upper: assert property (select_upper_bank_instr |=> bank_select)
        else $error("upper bank not selected");
    a_bank_hold: assert property (!select_lower_bank_instr && !select_upper_bank_instr |=> $stable(bank_select))
        else $error("bank changed without select");
    a_vector_reloc: assert property (s_settled |-> fetch_start == exp_vec)
        else $error("fetch start wrong");
    a_prog_refuse: assert property (prog_req.valid && prog_req.program_op && in_prot |=> prog_refused && !prog_accept)
        else $error("protected area not refused");
    a_prog_accept: assert property (prog_req.valid && !(prog_req.program_op && in_prot)
        |=> prog_accept && prog_addr == $past(prog_req.addr)) else $error("program request not accepted");
    a_vector_hit: assert property (prog_req.valid |=> prog_vector_hit == ($past(prog_req.addr) <= 16'h00FF))
        else $error("vector area hit wrong");
endmodule // rfm_map_asserts

bind rfm_map rfm_map_asserts rfm_map_asserts_i (.clk, .rstn, .reg_req, .select_lower_bank_instr,
    .select_upper_bank_instr, .prog_req, .option_isp_byte, .reg_rdata, .reg_rvalid, .reg_refused,
    .register_page_select, .working_slice_pointer_a, .working_slice_pointer_b, .bank_select, .fetch_start,
    .prog_vector_hit, .prog_refused, .prog_accept, .prog_addr);

// File: rfm_cpu.sv
`timescale 1ns/1ns
module rfm_cpu
    import rfm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [7:0]        reg_rdata,
    input  wire logic              reg_rvalid,
    input  wire logic              reg_refused,
    input  wire logic              display_page_hit,
    input  wire logic              periph_ctrl_hit,
    input  wire logic              prog_accept,
    input  wire logic              prog_refused,
    input  wire logic              prog_vector_hit,
    input  wire logic              prog_option_hit,
    output rfm_pkg::rfm_reg_req_t  reg_req,
    output logic                   select_lower_bank_instr,
    output logic                   select_upper_bank_instr,
    output rfm_pkg::rfm_prog_req_t prog_req
);
    initial begin
        reg_req = '0;
        prog_req = '0;
        select_lower_bank_instr = 1'b0;
        select_upper_bank_instr = 1'b0;
    end

    // Answer is taken one cycle after the request edge; released bus shows inverted data
    task automatic reg_op(input logic w, input logic d, input rfm_mode_t m, input logic [7:0] a,
                          input logic [7:0] wd, output logic [7:0] rd, output logic [7:0] fl);
        @(negedge clk);
        reg_req = '{1'b1, w, d, m, a, wd};
        @(negedge clk);
        rd = reg_rdata;
        fl = {4'h0, reg_rvalid, reg_refused, display_page_hit, periph_ctrl_hit};
        reg_req.valid = 1'b0;
        reg_req.addr = ~a;
        reg_req.wdata = ~wd;
    endtask

    task automatic prog_op(input logic po, input logic [15:0] a, output logic [7:0] fl);
        @(negedge clk);
        prog_req = '{1'b1, po, po, a, 8'h5A};
        @(negedge clk);
        fl = {4'h0, prog_accept, prog_refused, prog_vector_hit, prog_option_hit};
        prog_req.valid = 1'b0;
        prog_req.addr = ~a;
    endtask

    task automatic bank(input logic up);
        @(negedge clk);
        select_upper_bank_instr = up;
        select_lower_bank_instr = !up;
        @(negedge clk);
        select_upper_bank_instr = 1'b0;
        select_lower_bank_instr = 1'b0;
    endtask
endmodule // rfm_cpu

// File: rfm_map_bench.sv
`timescale 1ns/1ns
module rfm_map_bench;
    import rfm_pkg::*;
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    logic [7:0]    option_isp_byte = 8'h3A;
    rfm_reg_req_t  reg_req;
    rfm_prog_req_t prog_req;
    logic          select_lower_bank_instr, select_upper_bank_instr;
    logic [7:0]    reg_rdata, register_page_select, working_slice_pointer_a, working_slice_pointer_b;
    logic          reg_rvalid, reg_refused, display_page_hit, periph_ctrl_hit, bank_select;
    logic          prog_vector_hit, prog_option_hit, prog_refused, prog_accept;
    logic [15:0]   fetch_start, prog_addr;
    logic [7:0]    rd_v, fl_v;
    int            n_fail = 0;
    int            n_checks = 0;
    int            cyc = 0;

    always #10 clk = ~clk;

    rfm_map rfm_map_i (.clk, .rstn, .reg_req, .select_lower_bank_instr, .select_upper_bank_instr, .prog_req,
        .option_isp_byte, .reg_rdata, .reg_rvalid, .reg_refused, .display_page_hit, .periph_ctrl_hit,
        .register_page_select, .working_slice_pointer_a, .working_slice_pointer_b, .bank_select, .fetch_start,
        .prog_vector_hit, .prog_option_hit, .prog_refused, .prog_accept, .prog_addr);
    rfm_cpu rfm_cpu_i (.clk, .reg_rdata, .reg_rvalid, .reg_refused, .display_page_hit, .periph_ctrl_hit,
        .prog_accept, .prog_refused, .prog_vector_hit, .prog_option_hit, .reg_req, .select_lower_bank_instr,
        .select_upper_bank_instr, .prog_req);

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic d, input rfm_mode_t m, input logic [7:0] a, input logic [7:0] wd);
        rfm_cpu_i.reg_op(1'b1, d, m, a, wd, rd_v, fl_v);
    endtask
    task automatic rd(input logic d, input rfm_mode_t m, input logic [7:0] a);
        rfm_cpu_i.reg_op(1'b0, d, m, a, 8'h00, rd_v, fl_v);
    endtask
    task automatic do_reset(input logic [7:0] opt);
        @(negedge clk);
        option_isp_byte = opt;
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    task automatic t_reset_values();
        rd(1'b0, RFM_MODE_DIRECT, 8'hDF);
        chk8("page select", 8'h00, rd_v);
        rd(1'b0, RFM_MODE_DIRECT, 8'hD6);
        chk8("slice a", 8'hC0, rd_v);
        rd(1'b0, RFM_MODE_DIRECT, 8'hD7);
        chk8("slice b", 8'hC8, rd_v);
        chk8("bank", 8'h00, {7'h00, bank_select});
        chk16("fetch start", 16'h0300, fetch_start);
    endtask

    // Same offset on two pages, read back through the source nibble
    task automatic t_pages();
        wr(1'b0, RFM_MODE_DIRECT, 8'h40, 8'h3C);
        wr(1'b0, RFM_MODE_INDIRECT, 8'hC1, 8'h3C);
        wr(1'b0, RFM_MODE_DIRECT, 8'hDF, 8'h12);
        wr(1'b1, RFM_MODE_DIRECT, 8'h40, 8'hA5);
        wr(1'b1, RFM_MODE_INDEXED, 8'hC0, 8'hA5);
        wr(1'b0, RFM_MODE_DIRECT, 8'hDF, 8'h01);
        rd(1'b0, RFM_MODE_DIRECT, 8'h40);
        chk8("page 1 prime", 8'hA5, rd_v);
        wr(1'b0, RFM_MODE_DIRECT, 8'hDF, 8'h10);
        rd(1'b0, RFM_MODE_INDIRECT, 8'h40);
        chk8("page 0 prime", 8'h3C, rd_v);
        rd(1'b0, RFM_MODE_INDIRECT, 8'hC1);
        chk8("page 0 set 2", 8'h3C, rd_v);
        wr(1'b0, RFM_MODE_DIRECT, 8'hDF, 8'h00);
    endtask
    task automatic t_set1();
        wr(1'b0, RFM_MODE_DIRECT, 8'hE5, 8'h11);
        rfm_cpu_i.bank(1'b1);
        wr(1'b0, RFM_MODE_DIRECT, 8'hE5, 8'h22);
        rfm_cpu_i.bank(1'b0);
        rd(1'b0, RFM_MODE_DIRECT, 8'hE5);
        chk8("bank 0 reg", 8'h11, rd_v);
        rfm_cpu_i.bank(1'b1);
        wr(1'b0, RFM_MODE_INDIRECT, 8'hE5, 8'h33);
        rd(1'b0, RFM_MODE_DIRECT, 8'hE5);
        chk8("bank 1 reg", 8'h22, rd_v);
        rd(1'b0, RFM_MODE_INDEXED, 8'hE5);
        chk8("set 2 reg", 8'h33, rd_v);
        rd(1'b0, RFM_MODE_DIRECT, 8'hC5);
        chk8("common direct flags", 8'h04, fl_v);
    endtask
    task automatic t_working();
        wr(1'b0, RFM_MODE_WORKING, 8'h03, 8'h44);
        rd(1'b0, RFM_MODE_WORKING, 8'h03);
        chk8("working r3", 8'h44, rd_v);
        wr(1'b0, RFM_MODE_DIRECT, 8'hD7, 8'h40);
        wr(1'b0, RFM_MODE_WORKING, 8'h09, 8'h99);
        rd(1'b0, RFM_MODE_DIRECT, 8'h41);
        chk8("working r9", 8'h99, rd_v);
    endtask
    task automatic t_display();
        wr(1'b0, RFM_MODE_DIRECT, 8'hDF, 8'hFF);
        rd(1'b0, RFM_MODE_DIRECT, 8'hAF);
        chk8("display flags", 8'h0A, fl_v);
        rd(1'b0, RFM_MODE_DIRECT, 8'hB0);
        chk8("periph flags", 8'h09, fl_v);
        rd(1'b0, RFM_MODE_DIRECT, 8'hB1);
        chk8("plain flags", 8'h08, fl_v);
        wr(1'b0, RFM_MODE_DIRECT, 8'hDF, 8'h00);
    endtask

    // Protected area is 0100H..04FFH for option 3AH
    task automatic t_prog();
        logic [15:0] adr [6];
        logic [7:0]  flg [6];
        adr = '{16'h0150, 16'h04FF, 16'h0500, 16'h00FF, 16'h003E, 16'h003B};
        flg = '{8'h04, 8'h04, 8'h08, 8'h0A, 8'h0B, 8'h0A};
        for (int i = 0; i < 6; i++) begin
            rfm_cpu_i.prog_op(1'b1, adr[i], fl_v);
            chk8("prog flags", flg[i], fl_v);
        end
        rfm_cpu_i.prog_op(1'b0, 16'h0150, fl_v);
        chk8("prog read flags", 8'h08, fl_v);
        chk16("fetch start", 16'h0300, fetch_start);
    endtask

    task automatic t_vectors();
        logic [15:0] tbl [4];
        tbl = '{RFM_VEC_0200, RFM_VEC_0300, RFM_VEC_0500, RFM_VEC_0900};
        rfm_cpu_i.bank(1'b1);
        wr(1'b0, RFM_MODE_DIRECT, 8'hDF, 8'h34);
        for (int i = 0; i < 4; i++) begin
            do_reset({1'b0, i[1:0], 5'h07});
            chk16("fetch start", tbl[i], fetch_start);
            rfm_cpu_i.prog_op(1'b1, 16'h0150, fl_v);
            chk8("prog flags", 8'h08, fl_v);
        end
        chk8("bank", 8'h00, {7'h00, bank_select});
        rd(1'b0, RFM_MODE_DIRECT, 8'hDF);
        chk8("page select", 8'h00, rd_v);
        do_reset(8'hFF);
        chk16("fetch start", 16'h0100, fetch_start);
    endtask

    initial begin
        do_reset(8'h3A);
        t_reset_values();
        t_pages();
        t_set1();
        t_working();
        t_display();
        t_prog();
        t_vectors();
        finish_test();
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            finish_test();
        end
    end
endmodule // rfm_map_bench
